// ===== logic/timer_pwm_and_wide_capture.sv
// paired 8-bit timers with 16-bit capture and 10-bit pwm, avalon-mm slave
`timescale 1ns/100ps
`default_nettype none
module timer_pwm_and_wide_capture
   import timer_pwm_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [1:0] external_edge_input,
   input wire logic alt_out_b,
   input wire logic alt_out_d,
   output logic pulse_out_b_pin,
   output logic pulse_out_b_pin_oe,
   output logic pulse_out_d_pin,
   output logic pulse_out_d_pin_oe,
   output logic [3:0] match_pulse,
   output logic [1:0] edge_pulse
);
   if (ADDR_W < 7) begin : g_addr_check
      $error("ADDR_W too small for the register map");
   end

   // bus state
   logic wait_q, wait_d;
   logic [31:0] rd_q, rd_d;
   // per pair and global configuration
   logic [7:0] ctl_lo_q [2];
   logic [7:0] ctl_lo_d [2];
   logic [7:0] ctl_hi_q [2];
   logic [7:0] ctl_hi_d [2];
   logic [7:0] mlo_q [2];
   logic [7:0] mlo_d [2];
   logic [7:0] mhi_q [2];
   logic [7:0] mhi_d [2];
   logic [7:0] per_q [2];
   logic [7:0] per_d [2];
   logic [7:0] duty_q [2];
   logic [7:0] duty_d [2];
   logic [7:0] hb_q [2];
   logic [7:0] hb_d [2];
   logic [7:0] port_sel_q, port_sel_d;
   logic [7:0] edge_q, edge_d;
   // counting state
   logic [7:0] clo_q [2];
   logic [7:0] clo_d [2];
   logic [7:0] chi_q [2];
   logic [7:0] chi_d [2];
   logic [7:0] glo_q [2];
   logic [7:0] glo_d [2];
   logic [7:0] ghi_q [2];
   logic [7:0] ghi_d [2];
   logic [PRE_W-1:0] plo_q [2];
   logic [PRE_W-1:0] plo_d [2];
   logic [PRE_W-1:0] phi_q [2];
   logic [PRE_W-1:0] phi_d [2];
   logic [9:0] pcnt_q [2];
   logic [9:0] pcnt_d [2];
   logic [9:0] dact_q [2];
   logic [9:0] dact_d [2];
   // pins and events
   logic [1:0] ext_s1_q, ext_s2_q, ext_prev_q;
   logic [1:0] pin_q, pin_d, oe_q, oe_d;
   logic [3:0] match_q, match_d;
   logic [1:0] hit_q, hit_d;

   logic bus_go;
   logic wr_en;
   logic [7:0] loc;
   logic [7:0] wbyte;

   assign bus_go = (read | write) & wait_q;
   assign wr_en = write & ~wait_q & byteenable[0];
   assign loc = 8'(address);
   assign wbyte = writedata[7:0];

   always_comb begin
      logic p;
      logic [7:0] off;
      logic in_pair;
      logic hit, wide, run_lo, run_hi, pwm, sense;
      logic tick_lo, tick_hi;
      logic [PRE_W-1:0] div_hi;
      logic [15:0] wcnt;
      logic [9:0] period, duty, next_cnt;
      logic lvl;
      p = 1'b0;
      off = 8'h00;
      in_pair = 1'b0;
      hit = 1'b0;
      wide = 1'b0;
      run_lo = 1'b0;
      run_hi = 1'b0;
      pwm = 1'b0;
      sense = 1'b0;
      tick_lo = 1'b0;
      tick_hi = 1'b0;
      div_hi = '0;
      wcnt = 16'h0000;
      period = 10'h000;
      duty = 10'h000;
      next_cnt = 10'h000;
      lvl = 1'b0;
      // request answered one edge after it is seen
      wait_d = ~bus_go;
      rd_d = rd_q;
      port_sel_d = port_sel_q;
      edge_d = edge_q;
      match_d = 4'h0;
      hit_d = 2'b00;
      pin_d = pin_q;
      oe_d = oe_q;
      for (int i = 0; i < 2; i++) begin
         ctl_lo_d[i] = ctl_lo_q[i];
         ctl_hi_d[i] = ctl_hi_q[i];
         mlo_d[i] = mlo_q[i];
         mhi_d[i] = mhi_q[i];
         per_d[i] = per_q[i];
         duty_d[i] = duty_q[i];
         hb_d[i] = hb_q[i];
         clo_d[i] = clo_q[i];
         chi_d[i] = chi_q[i];
         glo_d[i] = glo_q[i];
         ghi_d[i] = ghi_q[i];
         plo_d[i] = plo_q[i];
         phi_d[i] = phi_q[i];
         pcnt_d[i] = pcnt_q[i];
         dact_d[i] = dact_q[i];
      end

      for (int i = 0; i < 2; i++) begin
         p = i[0];
         wide = ctl_hi_q[i][HI_WIDE_BIT];
         run_lo = ctl_lo_q[i][LO_RUN_BIT];
         run_hi = ctl_hi_q[i][HI_RUN_BIT];
         pwm = ctl_hi_q[i][HI_PWM_BIT];
         sense = ctl_hi_q[i][HI_SENSE_BIT];
         // only the synchronised copy feeds edge detection
         case (edge_sel_t'(edge_q[2*i +: 2]))
            EDGE_FALL: hit = ext_prev_q[i] & ~ext_s2_q[i];
            EDGE_RISE: hit = ~ext_prev_q[i] & ext_s2_q[i];
            EDGE_BOTH: hit = ext_prev_q[i] ^ ext_s2_q[i];
            default: hit = 1'b0;
         endcase
         hit_d[i] = hit;

         // low timer prescaler; in wide mode it clocks both counter bytes, pwm keeps the high prescaler
         tick_lo = run_lo & tick_due(plo_q[i],
                                     lo_div(ctl_lo_q[i][LO_SEL_MSB:0]));
         plo_d[i] = (!run_lo || tick_lo) ? '0 : plo_q[i] + 12'h001;
         div_hi = pwm ? src_div(ctl_hi_q[i][HI_SEL_MSB:0])
                      : hi_div(p, ctl_hi_q[i][HI_SEL_MSB:0]);
         tick_hi = run_hi & tick_due(phi_q[i], div_hi);
         phi_d[i] = (!run_hi || tick_hi) ? '0 : phi_q[i] + 12'h001;

         wcnt = {chi_q[i], clo_q[i]};
         if (wide) begin
            if (ctl_hi_q[i][HI_GRAB_BIT] && hit) begin
               // both bytes grabbed on one edge, then restart
               glo_d[i] = clo_q[i];
               ghi_d[i] = chi_q[i];
               clo_d[i] = 8'h00;
               chi_d[i] = 8'h00;
            end else if (tick_lo) begin
               if (wcnt == {mhi_q[i], mlo_q[i]}) begin
                  wcnt = 16'h0000;
                  match_d[2*i] = 1'b1;
               end else begin
                  wcnt = wcnt + 16'h0001;
               end
               clo_d[i] = wcnt[7:0];
               chi_d[i] = wcnt[15:8];
            end
         end else begin
            if (ctl_lo_q[i][LO_GRAB_BIT] && hit) begin
               glo_d[i] = clo_q[i];
               clo_d[i] = 8'h00;
            end else if (tick_lo) begin
               if (clo_q[i] == mlo_q[i]) begin
                  clo_d[i] = 8'h00;
                  match_d[2*i] = 1'b1;
               end else begin
                  clo_d[i] = clo_q[i] + 8'h01;
               end
            end
            if (!pwm) begin
               if (ctl_hi_q[i][HI_GRAB_BIT] && hit) begin
                  ghi_d[i] = chi_q[i];
                  chi_d[i] = 8'h00;
               end else if (tick_hi) begin
                  if (chi_q[i] == mhi_q[i]) begin
                     chi_d[i] = 8'h00;
                     match_d[2*i+1] = 1'b1;
                  end else begin
                     chi_d[i] = chi_q[i] + 8'h01;
                  end
               end
            end
         end

         // pwm on the high timer of each pair
         period = {hb_q[i][HB_PER_MSB:HB_PER_LSB], per_q[i]};
         duty = {hb_q[i][HB_DUTY_MSB:HB_DUTY_LSB], duty_q[i]};
         next_cnt = pcnt_q[i] + 10'h001;
         if (!(pwm && run_hi)) begin
            // stopped: counter parked, new duty taken at once
            pcnt_d[i] = 10'h000;
            dact_d[i] = duty;
         end else if (tick_hi) begin
            if (next_cnt >= period) begin
               pcnt_d[i] = 10'h000;
               dact_d[i] = duty;
            end else begin
               pcnt_d[i] = next_cnt;
            end
         end
         // period alone may change; the running duty copy stays
         if (dact_q[i] >= period) begin
            lvl = sense;
         end else if (pcnt_q[i] < dact_q[i]) begin
            lvl = sense;
         end else begin
            lvl = ~sense;
         end
         oe_d[i] = port_sel_q[i];
         if (port_sel_q[i] && pwm) begin
            pin_d[i] = lvl;
         end else begin
            pin_d[i] = (i == 0) ? alt_out_b : alt_out_d;
         end
      end

      // register writes
      if (wr_en) begin
         if (loc == OFS_PORT_SEL) begin
            port_sel_d = wbyte;
         end else if (loc == OFS_EDGE) begin
            edge_d = wbyte;
         end
         for (int i = 0; i < 2; i++) begin
            in_pair = (loc & ~PAIR_MASK) == 8'(i * PAIR_STRIDE);
            off = loc & PAIR_MASK;
            if (in_pair) begin
               case (off)
                  OFS_CTL_LO: ctl_lo_d[i] = wbyte;
                  OFS_CTL_HI: ctl_hi_d[i] = wbyte;
                  OFS_DATA_LO: mlo_d[i] = wbyte;
                  OFS_DATA_HI: mhi_d[i] = wbyte;
                  OFS_PERIOD: per_d[i] = wbyte;
                  OFS_DUTY: duty_d[i] = wbyte;
                  OFS_HIGH_BITS: hb_d[i] = wbyte;
                  default: ;
               endcase
            end
         end
      end

      // read mux, unmapped addresses read zero
      if (bus_go && read) begin
         rd_d = 32'h0000_0000;
         if (loc == OFS_PORT_SEL) begin
            rd_d[7:0] = port_sel_q;
         end else if (loc == OFS_EDGE) begin
            rd_d[7:0] = edge_q;
         end
         for (int i = 0; i < 2; i++) begin
            in_pair = (loc & ~PAIR_MASK) == 8'(i * PAIR_STRIDE);
            off = loc & PAIR_MASK;
            wide = ctl_hi_q[i][HI_WIDE_BIT];
            if (in_pair) begin
               case (off)
                  OFS_CTL_LO: rd_d[7:0] = ctl_lo_q[i];
                  OFS_CTL_HI: rd_d[7:0] = ctl_hi_q[i];
                  OFS_DATA_LO: rd_d[7:0] = (ctl_lo_q[i][LO_GRAB_BIT] ||
                     (wide && ctl_hi_q[i][HI_GRAB_BIT])) ?
                     glo_q[i] : mlo_q[i];
                  OFS_DATA_HI: rd_d[7:0] = ctl_hi_q[i][HI_GRAB_BIT] ?
                     ghi_q[i] : mhi_q[i];
                  OFS_PERIOD: rd_d[7:0] = per_q[i];
                  OFS_DUTY: rd_d[7:0] = duty_q[i];
                  OFS_HIGH_BITS: rd_d[7:0] = hb_q[i];
                  OFS_COUNT: rd_d[15:0] = {chi_q[i], clo_q[i]};
                  default: ;
               endcase
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wait_q <= 1'b1;
         rd_q <= 32'h0000_0000;
         port_sel_q <= RST_BYTE;
         edge_q <= RST_BYTE;
         ext_s1_q <= 2'b00;
         ext_s2_q <= 2'b00;
         ext_prev_q <= 2'b00;
         pin_q <= 2'b00;
         oe_q <= 2'b00;
         match_q <= 4'h0;
         hit_q <= 2'b00;
         for (int i = 0; i < 2; i++) begin
            ctl_lo_q[i] <= RST_BYTE;
            ctl_hi_q[i] <= RST_BYTE;
            mlo_q[i] <= RST_BYTE;
            mhi_q[i] <= RST_BYTE;
            per_q[i] <= RST_BYTE;
            duty_q[i] <= RST_BYTE;
            hb_q[i] <= RST_BYTE;
            clo_q[i] <= RST_BYTE;
            chi_q[i] <= RST_BYTE;
            glo_q[i] <= RST_BYTE;
            ghi_q[i] <= RST_BYTE;
            plo_q[i] <= '0;
            phi_q[i] <= '0;
            pcnt_q[i] <= 10'h000;
            dact_q[i] <= 10'h000;
         end
      end else begin
         wait_q <= wait_d;
         rd_q <= rd_d;
         port_sel_q <= port_sel_d;
         edge_q <= edge_d;
         ext_s1_q <= external_edge_input;
         ext_s2_q <= ext_s1_q;
         ext_prev_q <= ext_s2_q;
         pin_q <= pin_d;
         oe_q <= oe_d;
         match_q <= match_d;
         hit_q <= hit_d;
         for (int i = 0; i < 2; i++) begin
            ctl_lo_q[i] <= ctl_lo_d[i];
            ctl_hi_q[i] <= ctl_hi_d[i];
            mlo_q[i] <= mlo_d[i];
            mhi_q[i] <= mhi_d[i];
            per_q[i] <= per_d[i];
            duty_q[i] <= duty_d[i];
            hb_q[i] <= hb_d[i];
            clo_q[i] <= clo_d[i];
            chi_q[i] <= chi_d[i];
            glo_q[i] <= glo_d[i];
            ghi_q[i] <= ghi_d[i];
            plo_q[i] <= plo_d[i];
            phi_q[i] <= phi_d[i];
            pcnt_q[i] <= pcnt_d[i];
            dact_q[i] <= dact_d[i];
         end
      end
   end

   assign readdata = rd_q;
   assign waitrequest = wait_q;
   assign pulse_out_b_pin = pin_q[0];
   assign pulse_out_d_pin = pin_q[1];
   assign pulse_out_b_pin_oe = oe_q[0];
   assign pulse_out_d_pin_oe = oe_q[1];
   assign match_pulse = match_q;
   assign edge_pulse = hit_q;
endmodule
`default_nettype wire

// ===== logic/timer_pwm_pkg.sv
// constants, register map and helper functions of the paired timer block
package timer_pwm_pkg;
   // system clock
   localparam int CLK_NS = 20;
   // pwm source clock periods for select codes 00, 01, 10
   localparam int SRC0_NS = 250;
   localparam int SRC1_NS = 500;
   localparam int SRC2_NS = 2000;
   // a least period rounds up to whole clock cycles
   localparam int SRC0_CYC = (SRC0_NS + CLK_NS - 1) / CLK_NS;
   localparam int SRC1_CYC = (SRC1_NS + CLK_NS - 1) / CLK_NS;
   localparam int SRC2_CYC = (SRC2_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRE_W = 12;

   // register byte offsets inside one pair, pair stride, global registers
   localparam logic [7:0] OFS_CTL_LO = 8'h00;
   localparam logic [7:0] OFS_CTL_HI = 8'h04;
   localparam logic [7:0] OFS_DATA_LO = 8'h08;
   localparam logic [7:0] OFS_DATA_HI = 8'h0C;
   localparam logic [7:0] OFS_PERIOD = 8'h10;
   localparam logic [7:0] OFS_DUTY = 8'h14;
   localparam logic [7:0] OFS_HIGH_BITS = 8'h18;
   localparam logic [7:0] OFS_COUNT = 8'h1C;
   localparam logic [7:0] PAIR_STRIDE = 8'h20;
   localparam logic [7:0] OFS_PORT_SEL = 8'h40;
   localparam logic [7:0] OFS_EDGE = 8'h44;
   localparam logic [7:0] PAIR_MASK = 8'h1F;
   localparam logic [7:0] RST_BYTE = 8'h00;

   // low timer control fields
   localparam int LO_SEL_MSB = 2;
   localparam int LO_GRAB_BIT = 3;
   localparam int LO_RUN_BIT = 4;
   // high timer control fields
   localparam int HI_SEL_MSB = 1;
   localparam int HI_GRAB_BIT = 2;
   localparam int HI_WIDE_BIT = 3;
   localparam int HI_RUN_BIT = 4;
   localparam int HI_PWM_BIT = 5;
   localparam int HI_SENSE_BIT = 6;
   // high bits register fields
   localparam int HB_PER_MSB = 3;
   localparam int HB_PER_LSB = 2;
   localparam int HB_DUTY_MSB = 1;
   localparam int HB_DUTY_LSB = 0;

   typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BOTH, EDGE_OFF}
      edge_sel_t;

   // low timer prescaler divide ratios
   function automatic logic [PRE_W-1:0] lo_div(input logic [2:0] sel);
      case (sel)
         3'd0: lo_div = 12'h0002;
         3'd1: lo_div = 12'h0004;
         3'd2: lo_div = 12'h0008;
         3'd3: lo_div = 12'h0020;
         3'd4: lo_div = 12'h0080;
         3'd5: lo_div = 12'h0200;
         default: lo_div = 12'h0800;
      endcase
   endfunction

   // high timer divide ratios; the second pair has its own set
   function automatic logic [PRE_W-1:0] hi_div(input logic pair,
                                               input logic [1:0] sel);
      case (sel)
         2'd0: hi_div = 12'h0001;
         2'd1: hi_div = pair ? 12'h0004 : 12'h0002;
         default: hi_div = pair ? 12'h0010 : 12'h0008;
      endcase
   endfunction

   // pwm source clock in system clock cycles
   function automatic logic [PRE_W-1:0] src_div(input logic [1:0] sel);
      case (sel)
         2'd0: src_div = PRE_W'(SRC0_CYC);
         2'd1: src_div = PRE_W'(SRC1_CYC);
         default: src_div = PRE_W'(SRC2_CYC);
      endcase
   endfunction

   function automatic logic tick_due(input logic [PRE_W-1:0] cnt,
                                     input logic [PRE_W-1:0] div);
      tick_due = (cnt >= div - 12'h0001);
   endfunction
endpackage

// ===== dv/timer_pwm_monitor.sv
// concurrent checks on the ports of the paired timer block
`timescale 1ns/100ps
`default_nettype none
module timer_pwm_monitor
   import timer_pwm_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [1:0] external_edge_input,
   input wire logic alt_out_b,
   input wire logic alt_out_d,
   input wire logic pulse_out_b_pin,
   input wire logic pulse_out_b_pin_oe,
   input wire logic pulse_out_d_pin,
   input wire logic pulse_out_d_pin_oe,
   input wire logic [1:0] edge_pulse
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);

   wait_one_cycle_a: assert property ($fell(waitrequest) |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   bus_answer_a: assert property
      ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one cycle");
   read_upper_a: assert property (readdata[31:8] == 24'h00_0000)
      else $error("upper read data not zero");
   read_hold_a: assert property
      ($changed(readdata) |-> $past(read && waitrequest))
      else $error("read data changed without a read");
   edge_one_a: assert property (edge_pulse[0] |=> !edge_pulse[0])
      else $error("edge event on pair 0 wider than one cycle");
   edge_one_d_a: assert property (edge_pulse[1] |=> !edge_pulse[1])
      else $error("edge event on pair 1 wider than one cycle");
   // the pin reaches the grab logic through sync flops, so allow a window
   edge_cause_a: assert property ($rose(edge_pulse[0]) |->
      $past(external_edge_input[0], 1) != $past(external_edge_input[0], 6))
      else $error("edge event without a pin transition");
   alt_pin_b_a: assert property (!pulse_out_b_pin_oe &&
      $past(!pulse_out_b_pin_oe) && $past(reset_n) |->
      pulse_out_b_pin == $past(alt_out_b))
      else $error("disabled pin b does not follow other function");
   alt_pin_d_a: assert property (!pulse_out_d_pin_oe &&
      $past(!pulse_out_d_pin_oe) && $past(reset_n) |->
      pulse_out_d_pin == $past(alt_out_d))
      else $error("disabled pin d does not follow other function");
   oe_cause_a: assert property ($changed(pulse_out_b_pin_oe) |->
      $past(write && !waitrequest) || $past(write && !waitrequest, 2))
      else $error("pin enable changed without a write");

   cover property (edge_pulse[0]);
   cover property ($rose(pulse_out_b_pin) && pulse_out_b_pin_oe);
   cover property ($fell(waitrequest) && write);
endmodule

bind timer_pwm_and_wide_capture timer_pwm_monitor mon (.mclk, .reset_n,
   .read, .write, .readdata, .waitrequest, .external_edge_input,
   .alt_out_b, .alt_out_d, .pulse_out_b_pin, .pulse_out_b_pin_oe,
   .pulse_out_d_pin, .pulse_out_d_pin_oe, .edge_pulse);
`default_nettype wire

// ===== dv/pin_partner.sv
// far-side model: capture input levels and other-function pin levels
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [1:0] level_req,
   output logic [1:0] external_edge_input,
   output logic alt_out_b,
   output logic alt_out_d
);
   logic [2:0] pat_q;
   // other-function level b changes every cycle and d every fourth cycle, so a stuck pin shows up
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pat_q <= 3'h0;
         external_edge_input <= 2'h0;
      end else begin
         pat_q <= pat_q + 3'h1;
         external_edge_input <= level_req;
      end
   end
   assign alt_out_b = pat_q[0];
   assign alt_out_d = pat_q[1] ^ pat_q[2];
endmodule
`default_nettype wire

// ===== dv/timer_pwm_and_wide_capture_tb_top.sv
// self-checking bench for the paired timer, pwm and capture block
`timescale 1ns/100ps
`default_nettype none
module timer_pwm_and_wide_capture_tb_top
   import timer_pwm_pkg::*;
();
   logic mclk, reset_n, read, write, waitrequest;
   logic [7:0] address;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata;
   logic [1:0] ein, level_req, edge_pulse;
   logic [3:0] match_pulse;
   logic alt_b, alt_d, pb, pb_oe, pd, pd_oe;
   int fails, n_tests;
   int ecnt [2] = '{0, 0};

   timer_pwm_and_wide_capture uut (.mclk, .reset_n, .address, .read,
      .write, .byteenable, .writedata, .readdata, .waitrequest,
      .external_edge_input(ein), .alt_out_b(alt_b), .alt_out_d(alt_d),
      .pulse_out_b_pin(pb), .pulse_out_b_pin_oe(pb_oe),
      .pulse_out_d_pin(pd), .pulse_out_d_pin_oe(pd_oe), .match_pulse,
      .edge_pulse);
   pin_partner far_side (.mclk, .reset_n, .level_req,
      .external_edge_input(ein), .alt_out_b(alt_b), .alt_out_d(alt_d));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      for (int i = 0; i < 2; i++) if (edge_pulse[i] === 1'b1) ecnt[i]++;
   end

   task automatic chk(input bit ok, input string m);
      n_tests++;
      if (!ok) begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask

   // one idle edge first so a release and a new request never share a step
   task automatic bus(input logic is_wr, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      address <= a;
      writedata <= 32'(d);
      read <= !is_wr;
      write <= is_wr;
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0);
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
      chk(n === 2, "bus answer not after one wait state");
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rreg(input logic [7:0] a, output logic [7:0] q);
      bus(1'b0, a, 8'h00, q);
   endtask

   task automatic wait_pin(input int p, input logic v, output int n);
      n = 0;
      while ((p ? pd : pb) !== v && n < 9000) begin
         @(posedge mclk);
         n++;
      end
      chk(n < 9000, "pin level never reached");
   endtask

   task automatic measure(input int p, input logic s, output int act,
                          output int tot);
      int n;
      wait_pin(p, !s, n);
      wait_pin(p, s, n);
      wait_pin(p, !s, act);
      wait_pin(p, s, n);
      tot = act + n;
   endtask

   task automatic cfg(input int p, input logic [1:0] sel, input logic s,
                      input logic [9:0] per, input logic [9:0] dut);
      logic [7:0] b;
      b = p ? PAIR_STRIDE : 8'h00;
      wreg(b + OFS_CTL_HI, 8'h00);
      wreg(b + OFS_PERIOD, per[7:0]);
      wreg(b + OFS_DUTY, dut[7:0]);
      wreg(b + OFS_HIGH_BITS, {4'h0, per[9:8], dut[9:8]});
      wreg(OFS_PORT_SEL, 8'h03);
      wreg(b + OFS_CTL_HI, {1'b0, s, 6'h30} | 8'(sel));
      repeat (3) @(posedge mclk);
   endtask

   task automatic t_regs;
      logic [7:0] a [7] = '{OFS_CTL_LO, OFS_CTL_HI, OFS_DATA_LO,
         OFS_PERIOD, OFS_DUTY, OFS_HIGH_BITS, OFS_PORT_SEL};
      logic [7:0] q;
      for (int i = 0; i < 7; i++) begin
         rreg(a[i], q);
         chk(q === 8'h00, "register not zero after reset");
      end
      wreg(8'h48, 8'hA5);
      rreg(8'h48, q);
      chk(q === 8'h00, "unmapped address not zero");
      byteenable <= 4'h0;
      wreg(OFS_DUTY, 8'hA5);
      byteenable <= 4'h1;
      rreg(OFS_DUTY, q);
      chk(q === 8'h00, "write without byte lane took effect");
      wreg(OFS_PERIOD, 8'h5A);
      rreg(OFS_PERIOD, q);
      chk(q === 8'h5A, "period register read back");
   endtask

   task automatic t_codes;
      int act, tot, d;
      for (int c = 0; c < 3; c++) begin
         d = c == 0 ? SRC0_CYC : c == 1 ? SRC1_CYC : SRC2_CYC;
         cfg(0, 2'(c), 1'b1, 10'd4, 10'd1);
         measure(0, 1'b1, act, tot);
         chk(act === d && tot === 4 * d, "pwm timing per code");
      end
      cfg(0, 2'd0, 1'b0, 10'h201, 10'h100);
      measure(0, 1'b0, act, tot);
      chk(act === 256 * SRC0_CYC
         && tot === 513 * SRC0_CYC, "ten bit low active pwm");
      cfg(1, 2'd0, 1'b1, 10'd6, 10'd2);
      measure(1, 1'b1, act, tot);
      chk(act === 2 * SRC0_CYC && tot === 6 * SRC0_CYC, "pin d pwm");
   endtask

   task automatic t_const;
      logic [9:0] dv [4] = '{10'd4, 10'd4, 10'd0, 10'd0};
      logic s, e, ok;
      for (int k = 0; k < 4; k++) begin
         s = 1'(k);
         e = k < 2 ? s : !s;
         cfg(0, 2'd0, s, 10'd4, dv[k]);
         repeat (70) @(posedge mclk);
         ok = 1'b1;
         repeat (110) begin
            @(posedge mclk);
            if (pb !== e) ok = 1'b0;
         end
         chk(ok, "pwm level not constant");
      end
   endtask

   task automatic t_buffer;
      int n, act, tot;
      cfg(0, 2'd0, 1'b1, 10'd8, 10'd2);
      wait_pin(0, 1'b0, n);
      wait_pin(0, 1'b1, n);
      wreg(OFS_DUTY, 8'd6);
      wait_pin(0, 1'b0, n);
      chk(n + 3 === 2 * SRC0_CYC, "duty changed mid period");
      measure(0, 1'b1, act, tot);
      chk(act === 6 * SRC0_CYC && tot === 8 * SRC0_CYC, "new duty");
      wreg(OFS_PERIOD, 8'd12);
      measure(0, 1'b1, act, tot);
      measure(0, 1'b1, act, tot);
      chk(act === 6 * SRC0_CYC && tot === 12 * SRC0_CYC, "period");
   endtask

   task automatic t_alt;
      logic pv_b, pv_d, ok;
      wreg(OFS_PORT_SEL, 8'h00);
      repeat (2) @(posedge mclk);
      ok = 1'b1;
      pv_b = alt_b;
      pv_d = alt_d;
      repeat (20) begin
         @(posedge mclk);
         if (pb !== pv_b || pd !== pv_d || pb_oe !== 1'b0) ok = 1'b0;
         pv_b = alt_b;
         pv_d = alt_d;
      end
      chk(ok, "disabled pins not on other function");
      wreg(OFS_PORT_SEL, 8'h03);
      repeat (3) @(posedge mclk);
      chk(pb_oe === 1'b1 && pd_oe === 1'b1, "pin enables");
   endtask

   task automatic t_edges;
      int e [4] = '{1, 1, 2, 0};
      wreg(OFS_CTL_LO, 8'h18);
      wreg(PAIR_STRIDE + OFS_CTL_LO, 8'h18);
      for (int c = 0; c < 4; c++) begin
         wreg(OFS_EDGE, 8'(c * 5));
         ecnt = '{0, 0};
         level_req <= 2'b11;
         repeat (12) @(posedge mclk);
         level_req <= 2'b00;
         repeat (12) @(posedge mclk);
         chk(ecnt[0] === e[c] && ecnt[1] === e[c], "edge count");
      end
   endtask

   task automatic wait_ep(input int p, output int n);
      n = 0;
      while (edge_pulse[p] !== 1'b1 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      chk(n < 50, "capture event missing");
   endtask

   // timer a prescaler code 0 divides by two, so the grab is half the gap
   task automatic t_cap(input int p, input logic w);
      logic [7:0] b, lo, hi;
      int n, d, v;
      b = p ? PAIR_STRIDE : 8'h00;
      wreg(OFS_EDGE, 8'h0A);
      wreg(b + OFS_DATA_LO, 8'hFF);
      wreg(b + OFS_DATA_HI, 8'hFF);
      wreg(b + OFS_CTL_HI, w ? 8'h0F : 8'h00);
      wreg(b + OFS_CTL_LO, 8'h18);
      level_req[p] <= ~level_req[p];
      wait_ep(p, n);
      repeat (w ? 600 : 300) @(posedge mclk);
      level_req[p] <= ~level_req[p];
      wait_ep(p, n);
      d = (w ? 600 : 300) + n;
      rreg(b + OFS_DATA_LO, lo);
      rreg(b + OFS_DATA_HI, hi);
      v = w ? {hi, lo} : lo;
      chk(v >= d / 2 - 2 && v <= d / 2 + 1, "grabbed count");
   endtask

   // wide count on low prescaler code 0 (two cycles a tick), match 0x0200;
   // the count left by the captures is well below it, so no wrap first
   task automatic t_match;
      int n;
      wreg(OFS_DATA_LO, 8'h00);
      wreg(OFS_DATA_HI, 8'h02);
      wreg(OFS_CTL_HI, 8'h0B);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge mclk);
            n++;
         end while (match_pulse[0] !== 1'b1 && n < 2000);
      end
      chk(n === 513 * 2, "wide match period");
   endtask

   task automatic t_reset2;
      logic [7:0] q;
      cfg(0, 2'd0, 1'b1, 10'd4, 10'd2);
      repeat (30) @(posedge mclk);
      reset_n <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(pb === 1'b0 && pb_oe === 1'b0 && waitrequest === 1'b1, "in reset");
      reset_n <= 1'b1;
      rreg(OFS_CTL_HI, q);
      chk(q === 8'h00, "control not cleared by reset");
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      reset_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      byteenable = 4'h1;
      writedata = 32'h0000_0000;
      level_req = 2'b00;
      fails = 0;
      n_tests = 0;
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      t_regs;
      t_codes;
      t_const;
      t_buffer;
      t_alt;
      t_edges;
      t_cap(0, 1'b0);
      t_cap(0, 1'b1);
      t_cap(1, 1'b1);
      t_match;
      t_reset2;
      final_report;
   end

   // the longest scenario runs a few ten-bit periods of some 6700 cycles
   initial begin
      repeat (70000) @(posedge mclk);
      fails++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      final_report;
   end
endmodule
`default_nettype wire
